//--- tb/page_map_address_translator_asserts.sv
// Purpose: Port checks for the page map translator.
// Assumes: Bound to the translator top module.
// Notes: One clock domain, synchronous reset.
`timescale 1ns/100ps
module page_map_address_translator_asserts
    import page_map_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Access port.
    input wire logic acc_valid,
    input wire logical_req_t acc_req,
    input wire logic acc_ready,
    input wire logic code_data_separation,
    input wire logic int_service,
    // Memory and core returns.
    input wire phys_req_t phys_req,
    input wire logic core_rvalid,
    input wire logic [15:0] core_rdata,
    input wire logic accum_hit,
    input wire logic accum_sel_b,
    input wire logic protect_violation,
    // Command port and map state.
    input wire logic cmd_valid,
    input wire map_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic cmd_done,
    input wire logic priv_fault,
    input wire logic [15:0] a_result,
    input wire working_map_set_t working_map_set,
    input wire working_map_set_t interrupted_map_save,
    input wire logic protect_on
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Access checks
    // An access is taken when both valid and ready are high.
    wire take = acc_valid && acc_ready;
    wire via_exec = acc_req.fetch || acc_req.indirect || acc_req.map_sel == SEL_EXEC;
    a_dma_no_viol: assert property (take && acc_req.dma |=> !protect_violation)
        else $error("dma access flagged");
    a_viol_no_write: assert property (protect_violation |-> !phys_req.valid)
        else $error("violating access reached memory");
    a_read_viol_ones: assert property (take && !acc_req.write ##1 protect_violation
        |-> core_rvalid && core_rdata == 16'hFFFF) else $error("read violation data");
    a_offset_kept: assert property (take && !code_data_separation ##1 phys_req.valid
        |-> phys_req.addr[9:0] == $past(acc_req.addr[9:0])) else $error("offset altered");
    a_accum_exec: assert property (take && via_exec && acc_req.addr < 15'h0002
        |=> accum_hit && !phys_req.valid && accum_sel_b == $past(acc_req.addr[0]))
        else $error("exec accumulator access");
    a_data_map_mem: assert property (take && !via_exec |=> !accum_hit)
        else $error("data map hit accumulator");
    // ==========================================================
    // Map state and command checks
    a_int_swap: assert property (int_service |=> working_map_set.exec_map == 5'h00
        && working_map_set.first_data_map == $past(working_map_set.exec_map)
        && interrupted_map_save == $past(working_map_set) && !protect_on)
        else $error("interrupt map swap");
    a_load_incr: assert property (cmd_valid && cmd_ready && cmd.priv
        && cmd.op == OP_LOAD_ENTRY |=> cmd_done && a_result == $past(cmd.a_val) + 16'h0001)
        else $error("load entry result");
    a_priv_fault: assert property (cmd_valid && cmd_ready && !cmd.priv
        |=> cmd_done && priv_fault) else $error("unprivileged command ran");
    c_violation: cover property (protect_violation);
    c_accum: cover property (accum_hit);
    c_int: cover property (int_service);
endmodule
bind page_map_address_translator page_map_address_translator_asserts chk_i (.*);

//--- tb/page_map_address_translator_test.sv
// Purpose: Self-checking bench for the page map translator.
// Assumes: Memory model answers reads after three cycles.
// Notes: Each scenario is one task.
`timescale 1ns/100ps
module page_map_address_translator_test;
    import page_map_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic acc_valid = 1'b0, code_data_separation = 1'b0, protect_arm = 1'b0;
    logic int_service = 1'b0, cmd_valid = 1'b0, mem_rvalid, acc_ready;
    logic [15:0] base_value = 16'h0000, mem_rdata;
    logical_req_t acc_req = '0;
    map_cmd_t cmd = '0;
    phys_req_t phys_req, got_phys;
    logic core_rvalid, accum_hit, accum_sel_b, protect_violation, protect_on;
    logic cmd_ready, cmd_done, priv_fault, got_hit, got_viol, got_fault;
    logic [15:0] core_rdata, a_result, b_result, got_data;
    working_map_set_t working_map_set, interrupted_map_save;
    int mismatches = 0, n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    page_map_address_translator dut (.*);
    phys_mem_model #(.LAT(3)) mem_i (.*);
    // ==========================================================
    // Shared tasks
    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Runs one core access and captures what comes back.
    task automatic acc(input logic w, f, d, i, input map_sel_t s, input logic [14:0] a,
                       input logic [15:0] wd);
        @(posedge clk_sys);
        acc_req <= '{w, f, d, i, s, a, wd};
        acc_valid <= 1'b1;
        do @(negedge clk_sys); while (!acc_ready);
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        @(negedge clk_sys);
        got_phys = phys_req;
        got_hit = accum_hit;
        got_viol = protect_violation;
        // A memory read returns a few cycles later.
        while (!w && got_phys.valid && !core_rvalid) @(negedge clk_sys);
        got_data = core_rdata;
    endtask
    // Runs one mapping command up to its done pulse.
    task automatic run_cmd(input map_op_t op, input logic p, input logic [15:0] a, b,
                           input logic [4:0] m, input logic [14:0] img);
        @(posedge clk_sys);
        cmd <= '{op, p, a, b, m, img};
        cmd_valid <= 1'b1;
        do @(negedge clk_sys); while (!cmd_ready);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        do @(negedge clk_sys); while (!cmd_done);
        got_fault = priv_fault;
    endtask
    // ==========================================================
    // Scenarios
    // Loads a few entries; A carries junk high bits.
    task automatic t_entries();
        logic [15:0] idx [7] = '{16'hFC00, 16'h0001, 16'h0002, 16'h0003, 16'h0061,
                                 16'h0021, 16'h0060};
        logic [15:0] val [7] = '{16'h0011, 16'h0012, 16'h4034, 16'h8056, 16'h0078,
                                 16'h009A, 16'h00BC};
        for (int i = 0; i < 7; i++) begin
            run_cmd(OP_LOAD_ENTRY, 1'b1, idx[i], val[i], 5'h00, 15'h0000);
            chk(a_result, idx[i] + 16'h0001);
        end
        run_cmd(OP_STORE_ENTRY, 1'b1, 16'hF803, 16'h0000, 5'h00, 15'h0000);
        chk({b_result, a_result}, {16'h8056, 16'hF804});
        run_cmd(OP_LOAD_ENTRY, 1'b0, 16'h0001, 16'h7777, 5'h00, 15'h0000);
        chk(got_fault, 1'b1);
        run_cmd(OP_STORE_ENTRY, 1'b1, 16'h0001, 16'h0000, 5'h00, 15'h0000);
        chk({got_fault, b_result}, {1'b0, 16'h0012});
        $display("entry test done");
    endtask
    // Write then read back through the execute map.
    task automatic t_translate();
        acc(1, 0, 0, 0, SEL_EXEC, 15'h0405, 16'h1234);
        chk({got_phys.valid, got_phys.write, got_phys.addr}, {2'b11, 24'h004805});
        acc(0, 0, 0, 0, SEL_EXEC, 15'h0405, 16'h0000);
        chk(got_data, 16'h1234);
        $display("translate test done");
    endtask
    // Protected pages with and without DMA, then the interrupt swap.
    task automatic t_protect();
        @(posedge clk_sys) protect_arm <= 1'b1;
        @(posedge clk_sys) protect_arm <= 1'b0;
        acc(1, 0, 1, 0, SEL_EXEC, 15'h0807, 16'h0BAD);
        chk({got_viol, got_phys.valid}, 2'b01);
        acc(1, 0, 0, 0, SEL_EXEC, 15'h0807, 16'h5555);
        chk({got_viol, got_phys.valid}, 2'b10);
        chk(mem_i.peek(24'h00D007), 16'h0BAD);
        acc(0, 0, 0, 0, SEL_EXEC, 15'h0C09, 16'h0000);
        chk({got_viol, got_data}, {1'b1, 16'hFFFF});
        acc(0, 0, 1, 0, SEL_EXEC, 15'h0C09, 16'h0000);
        chk({got_viol, got_data}, {1'b0, 16'h5809 ^ 16'hA5A5});
        @(posedge clk_sys) int_service <= 1'b1;
        @(posedge clk_sys) int_service <= 1'b0;
        @(negedge clk_sys);
        chk({interrupted_map_save, working_map_set.exec_map, protect_on}, 21'h0018C0);
        $display("protect test done");
    endtask
    // Accumulator addresses, data maps and separation mode.
    task automatic t_maps();
        run_cmd(OP_LOAD_FIRST_DATA_MAP, 1'b1, 16'h0000, 16'h0000, 5'h03, 15'h0000);
        run_cmd(OP_LOAD_SECOND_DATA_MAP, 1'b1, 16'h0000, 16'h0000, 5'h03, 15'h0000);
        acc(0, 0, 0, 0, SEL_EXEC, 15'h0001, 16'h0000);
        chk({got_hit, accum_sel_b, got_phys.valid}, 3'b110);
        acc(0, 0, 0, 1, SEL_FIRST_DATA_MAP, 15'h0000, 16'h0000);
        chk({got_hit, got_phys.valid}, 2'b10);
        acc(1, 0, 0, 0, SEL_FIRST_DATA_MAP, 15'h0001, 16'h2222);
        chk({got_hit, got_phys.addr}, {1'b0, 24'h02F001});
        acc(1, 0, 0, 0, SEL_SECOND_DATA_MAP, 15'h0401, 16'h3333);
        chk(got_phys.addr, 24'h01E001);
        @(posedge clk_sys) code_data_separation <= 1'b1;
        base_value <= 16'h0400;
        acc(0, 1, 0, 0, SEL_EXEC, 15'h0405, 16'h0000);
        chk(got_phys.addr, 24'h026805);
        acc(1, 0, 0, 0, SEL_EXEC, 15'h0005, 16'h4444);
        chk(got_phys.addr, 24'h004805);
        acc(1, 0, 0, 0, SEL_FIRST_DATA_MAP, 15'h0005, 16'h4444);
        chk(got_phys.addr, 24'h02F005);
        @(posedge clk_sys) code_data_separation <= 1'b0;
        $display("map test done");
    endtask
    // Stores map 0 to memory, loads it into map 2 and reads one entry.
    task automatic t_transfer();
        run_cmd(OP_MAP_STORE, 1'b1, 16'h0000, 16'h0000, 5'h00, 15'h0800);
        chk(mem_i.peek(24'h00D001), 16'h0012);
        chk(mem_i.peek(24'h00D003), 16'h8056);
        run_cmd(OP_MAP_LOAD, 1'b1, 16'h0000, 16'h0000, 5'h02, 15'h0800);
        run_cmd(OP_STORE_ENTRY, 1'b1, 16'h0042, 16'h0000, 5'h00, 15'h0000);
        chk(b_result, 16'h4034);
        $display("transfer test done");
    endtask
    // ==========================================================
    // Sequence, verdict and watchdog
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_entries();
        t_translate();
        t_maps();
        t_protect();
        t_transfer();
        summarize();
    end
    initial begin
        #(20000 * 4);
        mismatches++;
        summarize();
    end
endmodule

//--- tb/phys_mem_model.sv
// Purpose: Physical memory behind the translator.
// Assumes: Takes a request every cycle, answers reads in order.
// Notes: LAT sets read latency, 1 to 4 cycles.
`timescale 1ns/100ps
module phys_mem_model
    import page_map_pkg::*;
#(
    parameter int LAT = 3
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Request and answer.
    input wire phys_req_t phys_req,
    output logic mem_rvalid,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [int]; // Sparse word store.
    logic [3:0] pv; // Read answer pipeline valids.
    logic [15:0] pd [4]; // Read answer pipeline data.
    // Unwritten words read as an address pattern.
    function automatic logic [15:0] peek(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : a[15:0] ^ 16'hA5A5;
    endfunction
    // Writes land first so a later read sees them.
    always @(posedge clk_sys) begin
        if (phys_req.valid && phys_req.write) begin
            mem[phys_req.addr] = phys_req.wdata;
        end
        pv <= rst_n ? {pv[2:0], phys_req.valid & ~phys_req.write} : 4'h0;
        pd[0] <= peek(phys_req.addr);
        for (int i = 1; i < 4; i++) begin
            pd[i] <= pd[i-1];
        end
    end
    // Between answers the data lines show the inverse of the word now in pipeline stage LAT, not the last answered word.
    assign mem_rvalid = pv[LAT-1];
    assign mem_rdata = pv[LAT-1] ? pd[LAT-1] : ~pd[LAT-1];
endmodule

//--- verilog/page_map_address_translator.sv
// Purpose: Page map translation, protection and map instruction engine.
// Assumes: One outstanding core read; memory takes a request each cycle.
// Notes: Pointer indirection and restart are resolved by the core.
//
// Contract
// - Logical address splits into page and offset.
// - Map number and page select one entry.
// - Physical address is page number plus offset.
// - Entry holds read, write protect, page.
// - Protected access flags a violation.
// - Read violation returns all ones.
// - Write violation suppresses the memory write.
// - DMA bypasses all protection checks.
// - Violation signals the memory protect logic.
// - Working set holds execute and data maps.
// - Execute map addresses 0,1 reach accumulators.
// - Separated fetches use execute map ORed 1.
// - Interrupt saves set, retargets maps, unprotects.
// - Execute data accesses get base added; the code adds it only in separation mode, for addresses 0x0002 to 0x03FF.
// - Indirect pointers always use execute map.
// - Entry and map instructions need privilege.
// - Load entry from B at A, increment.
// - Store entry at A into B, increment.
// - Map load copies image into map.
// - Map store copies map into memory.
// - Thirty-two maps of thirty-two entries.
// - Map transfers reference memory via execute map.
`timescale 1ns/100ps
`include "page_map_regs.svh"

module page_map_address_translator
    import page_map_pkg::*;
#(
    parameter int MAPS = 32,
    parameter int PAGES = 32
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Logical access from the core.
    input wire logic acc_valid,
    input wire logical_req_t acc_req,
    output logic acc_ready,
    // Mode inputs from the core.
    input wire logic code_data_separation,
    input wire logic [15:0] base_value,
    input wire logic protect_arm,
    input wire logic int_service,
    // Physical memory side.
    output phys_req_t phys_req,
    input wire logic mem_rvalid,
    input wire logic [15:0] mem_rdata,
    // Read data back to the core.
    output logic core_rvalid,
    output logic [15:0] core_rdata,
    output logic accum_hit,
    output logic accum_sel_b,
    // Protection event.
    output logic protect_violation,
    // Mapping instruction port.
    input wire logic cmd_valid,
    input wire map_cmd_t cmd,
    output logic cmd_ready,
    output logic cmd_done,
    output logic priv_fault,
    output logic [15:0] a_result,
    output logic [15:0] b_result,
    // Map state seen by software.
    output working_map_set_t working_map_set,
    output working_map_set_t interrupted_map_save,
    output logic protect_on
);

    // ==========================================================
    // Elaboration checks
    // The index arithmetic only serves 32 maps of 32 pages.
    if (MAPS != 32 || PAGES != 32) begin : g_bad_size
        $error("Map geometry must be 32 by 32.");
    end

    // ==========================================================
    // Storage and state
    typedef enum logic [1:0] {S_IDLE, S_RD_ISSUE, S_RD_WAIT, S_WR_ISSUE} seq_t;

    logic [15:0] entries [MAPS*PAGES]; // Page mapping entries.
    seq_t state, next_state; // Map transfer sequencer.
    logic [4:0] seq_idx, next_seq_idx; // Word within the map.
    logic [4:0] seq_map, next_seq_map; // Map being moved.
    logic [14:0] seq_image, next_seq_image; // Image base address.
    working_map_set_t next_working_map_set;
    working_map_set_t next_interrupted_map_save;
    logic next_protect_on;
    phys_req_t next_phys_req;
    logic next_core_rvalid, next_accum_hit, next_accum_sel_b;
    logic [15:0] next_core_rdata;
    logic next_protect_violation, next_cmd_done, next_priv_fault;
    logic [15:0] next_a_result, next_b_result;
    logic ent_we; // Entry array write strobe.
    logic [9:0] ent_widx; // Entry array write index.
    logic [15:0] ent_wdata; // Entry array write data.

    // ==========================================================
    // Decoding functions
    // Joins a map number and a logical page into an entry index.
    function automatic logic [9:0] entry_index(input logic [4:0] map_num,
                                               input logic [4:0] page);
        entry_index = {map_num, page};
    endfunction

    // Forms a physical address from an entry and an offset.
    function automatic logic [23:0] phys_of(input logic [15:0] entry,
                                            input logic [9:0] offset);
        phys_of = {entry[`ENTRY_PAGE_MSB:0], offset};
    endfunction

    // ==========================================================
    // Translation of the current access
    logic take_acc, take_cmd, seq_busy, is_priv_op;
    logic [4:0] use_map;
    logic [14:0] eff_addr;
    logic [15:0] cur_entry;
    logic exec_path, cur_write, cur_go, cur_dma;
    logic viol_rd, viol_wr, accum_ref;

    assign seq_busy = (state != S_IDLE);
    assign cmd_ready = !seq_busy;
    assign acc_ready = !seq_busy && !cmd_valid;
    assign take_acc = acc_valid && acc_ready;
    assign take_cmd = cmd_valid && cmd_ready;

    // Picks the map, applies base relocation and checks protection.
    always_comb begin
        exec_path = 1'b1;
        use_map = working_map_set.exec_map;
        eff_addr = seq_image + 15'(seq_idx);
        cur_write = (state == S_WR_ISSUE);
        cur_go = (state == S_RD_ISSUE) || (state == S_WR_ISSUE);
        cur_dma = 1'b0;
        if (!seq_busy) begin
            cur_go = take_acc;
            cur_write = acc_req.write;
            cur_dma = acc_req.dma;
            eff_addr = acc_req.addr;
            if (acc_req.indirect || acc_req.fetch || acc_req.map_sel == SEL_EXEC) begin
                use_map = working_map_set.exec_map;
                if (acc_req.fetch && code_data_separation) begin
                    use_map = working_map_set.exec_map | `CODE_MAP_OR;
                end else if (code_data_separation && acc_req.addr >= `BASE_REL_LO
                             && acc_req.addr <= `BASE_REL_HI) begin
                    eff_addr = acc_req.addr + base_value[14:0];
                end
            end else begin
                exec_path = 1'b0; // No base addition in data maps.
                use_map = (acc_req.map_sel == SEL_FIRST_DATA_MAP) ?
                          working_map_set.first_data_map :
                          working_map_set.second_data_map;
            end
        end
        // Upper five bits are the page, lower ten the offset.
        cur_entry = entries[entry_index(use_map, eff_addr[14:10])];
        accum_ref = !seq_busy && exec_path && acc_req.addr < `ACCUM_LIMIT;
        viol_rd = protect_on && !cur_dma && !cur_write
                  && cur_entry[`ENTRY_RP_BIT];
        viol_wr = protect_on && !cur_dma && cur_write
                  && cur_entry[`ENTRY_WP_BIT];
    end

    // Drives memory, read return and violation flag from the translation.
    always_comb begin
        next_phys_req = '0;
        next_accum_hit = 1'b0;
        next_accum_sel_b = 1'b0;
        next_protect_violation = 1'b0;
        next_core_rvalid = 1'b0;
        next_core_rdata = core_rdata;
        if (cur_go && accum_ref) begin
            next_accum_hit = 1'b1;
            next_accum_sel_b = acc_req.addr[0];
        end else if (cur_go) begin
            next_protect_violation = viol_rd || viol_wr;
            // A read violation skips memory; a write violation drops it.
            next_phys_req.valid = !(viol_rd || viol_wr);
            next_phys_req.write = cur_write;
            next_phys_req.addr = phys_of(cur_entry, eff_addr[9:0]);
            next_phys_req.wdata = seq_busy ?
                entries[entry_index(seq_map, seq_idx)] : acc_req.wdata;
            if (viol_rd) begin
                next_core_rvalid = 1'b1;
                next_core_rdata = `READ_VIOL_DATA;
            end
        end
        // Memory data goes to the core unless the sequencer wants it.
        if (mem_rvalid && state != S_RD_WAIT) begin
            next_core_rvalid = 1'b1;
            next_core_rdata = mem_rdata;
        end
    end

    // Registers the access outputs.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phys_req <= '0;
            accum_hit <= 1'b0;
            accum_sel_b <= 1'b0;
            protect_violation <= 1'b0;
            core_rvalid <= 1'b0;
            core_rdata <= 16'h0000;
        end else begin
            phys_req <= next_phys_req;
            accum_hit <= next_accum_hit;
            accum_sel_b <= next_accum_sel_b;
            protect_violation <= next_protect_violation;
            core_rvalid <= next_core_rvalid;
            core_rdata <= next_core_rdata;
        end
    end

    // ==========================================================
    // Mapping instructions and map state
    // Runs single-cycle instructions and steps the map transfers.
    always_comb begin
        next_state = state;
        next_seq_idx = seq_idx;
        next_seq_map = seq_map;
        next_seq_image = seq_image;
        next_working_map_set = working_map_set;
        next_interrupted_map_save = interrupted_map_save;
        next_protect_on = protect_on;
        next_cmd_done = 1'b0;
        next_priv_fault = 1'b0;
        next_a_result = a_result;
        next_b_result = b_result;
        ent_we = 1'b0;
        ent_widx = cmd.a_val[9:0];
        ent_wdata = cmd.b_val;
        is_priv_op = 1'b1;
        if (protect_arm) begin
            next_protect_on = 1'b1;
        end
        case (state)
            S_IDLE: begin
                if (take_cmd && is_priv_op && !cmd.priv) begin
                    next_priv_fault = 1'b1;
                    next_cmd_done = 1'b1;
                end else if (take_cmd) begin
                    case (cmd.op)
                        OP_LOAD_ENTRY: begin
                            ent_we = 1'b1;
                            next_a_result = cmd.a_val + 16'h0001;
                            next_cmd_done = 1'b1;
                        end
                        OP_STORE_ENTRY: begin
                            next_b_result = entries[cmd.a_val[9:0]];
                            next_a_result = cmd.a_val + 16'h0001;
                            next_cmd_done = 1'b1;
                        end
                        OP_MAP_LOAD, OP_MAP_STORE: begin
                            next_seq_map = cmd.map_num;
                            next_seq_image = cmd.image;
                            next_seq_idx = 5'h00;
                            next_state = (cmd.op == OP_MAP_LOAD) ?
                                         S_RD_ISSUE : S_WR_ISSUE;
                        end
                        OP_LOAD_FIRST_DATA_MAP: begin
                            next_working_map_set.first_data_map = cmd.map_num;
                            next_cmd_done = 1'b1;
                        end
                        OP_LOAD_SECOND_DATA_MAP: begin
                            next_working_map_set.second_data_map = cmd.map_num;
                            next_cmd_done = 1'b1;
                        end
                        default: begin
                            next_cmd_done = 1'b1;
                        end
                    endcase
                end
            end
            S_RD_ISSUE: begin
                next_state = S_RD_WAIT;
            end
            S_RD_WAIT: begin
                // Each image word lands in the next entry of the map.
                if (mem_rvalid) begin
                    ent_we = 1'b1;
                    ent_widx = entry_index(seq_map, seq_idx);
                    ent_wdata = mem_rdata;
                    next_seq_idx = seq_idx + 5'h01;
                    next_state = S_RD_ISSUE;
                    if (seq_idx == `MAP_LAST_WORD) begin
                        next_state = S_IDLE;
                        next_cmd_done = 1'b1;
                    end
                end
            end
            S_WR_ISSUE: begin
                // One entry leaves per cycle until the map is done.
                next_seq_idx = seq_idx + 5'h01;
                if (seq_idx == `MAP_LAST_WORD) begin
                    next_state = S_IDLE;
                    next_cmd_done = 1'b1;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // Interrupt service takes over the working set last.
        if (int_service) begin
            next_interrupted_map_save = working_map_set;
            next_working_map_set.first_data_map = working_map_set.exec_map;
            next_working_map_set.exec_map = `MAP_NUM_RESET;
            next_protect_on = 1'b0;
        end
    end

    // Registers the sequencer, map state and instruction results.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= S_IDLE;
            seq_idx <= 5'h00;
            seq_map <= `MAP_NUM_RESET;
            seq_image <= 15'h0000;
            working_map_set <= '0;
            interrupted_map_save <= '0;
            protect_on <= `PROTECT_RESET;
            cmd_done <= 1'b0;
            priv_fault <= 1'b0;
            a_result <= 16'h0000;
            b_result <= 16'h0000;
        end else begin
            state <= next_state;
            seq_idx <= next_seq_idx;
            seq_map <= next_seq_map;
            seq_image <= next_seq_image;
            working_map_set <= next_working_map_set;
            interrupted_map_save <= next_interrupted_map_save;
            protect_on <= next_protect_on;
            cmd_done <= next_cmd_done;
            priv_fault <= next_priv_fault;
            a_result <= next_a_result;
            b_result <= next_b_result;
        end
    end

    // Writes the entry array; its contents are not reset.
    always_ff @(posedge clk_sys) begin
        if (ent_we) begin
            entries[ent_widx] <= ent_wdata;
        end
    end

endmodule

//--- verilog/page_map_pkg.sv
// Purpose: Types shared by the page map address translator.
// Assumes: Constants come from page_map_regs.svh.
// Notes: Structs carry grouped request and map signals.
package page_map_pkg;

    // ==========================================================
    // Map selectors and commands
    // ==========================================================
    typedef enum logic [1:0] {SEL_EXEC, SEL_FIRST_DATA_MAP, SEL_SECOND_DATA_MAP} map_sel_t;

    typedef enum logic [2:0] {
        OP_LOAD_ENTRY, OP_STORE_ENTRY, OP_MAP_LOAD, OP_MAP_STORE,
        OP_LOAD_FIRST_DATA_MAP, OP_LOAD_SECOND_DATA_MAP
    } map_op_t;

    // ==========================================================
    // Grouped signals
    // ==========================================================
    typedef struct packed {
        logic [4:0] exec_map;
        logic [4:0] first_data_map;
        logic [4:0] second_data_map;
    } working_map_set_t;

    typedef struct packed {
        logic write;
        logic fetch;
        logic dma;
        logic indirect;
        map_sel_t map_sel;
        logic [14:0] addr;
        logic [15:0] wdata;
    } logical_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } phys_req_t;

    typedef struct packed {
        map_op_t op;
        logic priv;
        logic [15:0] a_val;
        logic [15:0] b_val;
        logic [4:0] map_num;
        logic [14:0] image;
    } map_cmd_t;

endpackage

//--- verilog/page_map_regs.svh
// Purpose: Constants for the page map address translator.
// Assumes: Included by bare name from the translator module.
// Notes: Holds field positions, fixed values and reset values.
`ifndef PAGE_MAP_REGS_SVH
`define PAGE_MAP_REGS_SVH

// ==========================================================
// Entry field layout
// ==========================================================
`define ENTRY_RP_BIT 15
`define ENTRY_WP_BIT 14
`define ENTRY_PAGE_MSB 13

// ==========================================================
// Fixed values
// ==========================================================
`define READ_VIOL_DATA 16'hFFFF
`define BASE_REL_LO 15'h0002
`define BASE_REL_HI 15'h03FF
`define ACCUM_LIMIT 15'h0002
`define CODE_MAP_OR 5'h01
`define MAP_LAST_WORD 5'h1F

// ==========================================================
// Reset values
// ==========================================================
`define MAP_NUM_RESET 5'h00
`define PROTECT_RESET 1'b0

`endif
